// >>> sync_coast_control_regs.sv
`timescale 1ns/1ps
// Contract
// - coast select: 0 coast pin, 1 vsync
// - sleep bit low powers chip down
// - separator counts to threshold, reset 0x20
// - scan enable bit gates scan
// - coast polarity override uses forced bit 6
// - hsync polarity override uses forced bit 7
// - status bit 7: hsync input polarity
// - status bit 6: vsync output, inverted sense
// - status bit 5: coast input polarity
// - control_b [7:3] slicer threshold, reset 10111
// - coast asserted N hsyncs before vsync
// - coast held N hsyncs after vsync
module sync_coast_control_regs (
  input wire logic clock,
  input wire logic reset,
  input wire logic [sync_coast_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire sync_coast_pkg::sync_in_t sync_pins,
  output logic pll_coast,
  output logic chip_sleep_n,
  output logic scan_enable,
  output logic sep_vsync,
  output logic [4:0] slicer_threshold,
  output logic [7:0] factory_test
);
  import sync_coast_pkg::*;

  sync_in_t meta;
  sync_in_t pins;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta <= '0;
      pins <= '0;
    end else begin
      meta <= sync_pins;
      pins <= meta;
    end
  end

  // register file
  logic [7:0] sync_separator_count_limit;
  logic [7:0] control_bits_a;
  logic [7:0] control_bits_b;
  logic [7:0] hold_count_before_vsync;
  logic [7:0] hold_count_after_vsync;
  logic [7:0] misc_ctrl;
  logic [7:0] pol_force;
  logic [7:0] next_sep_limit, next_ctrl_a, next_ctrl_b;
  logic [7:0] next_hold_before, next_hold_after, next_test, next_misc, next_force;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  pol_status_t pol_status;
  logic access;
  logic wr_ok;

  assign access = (read | write) & waitrequest;
  assign wr_ok = write & ~waitrequest & byteenable[0];

  always_comb begin
    next_sep_limit = sync_separator_count_limit;
    next_ctrl_a = control_bits_a;
    next_ctrl_b = control_bits_b;
    next_hold_before = hold_count_before_vsync;
    next_hold_after = hold_count_after_vsync;
    next_test = factory_test;
    next_misc = misc_ctrl;
    next_force = pol_force;
    next_readdata = readdata;
    next_waitrequest = ~access;
    if (wr_ok) begin
      unique case (address)
        OFF_SEP_LIMIT: next_sep_limit = writedata[7:0];
        OFF_CTRL_A: next_ctrl_a = writedata[7:0];
        OFF_CTRL_B: next_ctrl_b = {writedata[7:2], 2'b00};
        OFF_HOLD_BEFORE: next_hold_before = writedata[7:0];
        OFF_HOLD_AFTER: next_hold_after = writedata[7:0];
        OFF_FACTORY_TEST: next_test = writedata[7:0];
        OFF_MISC_CTRL: next_misc = {6'h00, writedata[1:0]};
        OFF_POL_FORCE: next_force = {writedata[7:6], 6'h00};
        default: next_force = pol_force; // status and unmapped
      endcase
    end
    if (read & waitrequest) begin
      unique case (address)
        OFF_SEP_LIMIT: next_readdata = {24'h000000, sync_separator_count_limit};
        OFF_CTRL_A: next_readdata = {24'h000000, control_bits_a};
        OFF_POL_STATUS: next_readdata = {24'h000000, pol_status, 5'h00};
        OFF_CTRL_B: next_readdata = {24'h000000, control_bits_b};
        OFF_HOLD_BEFORE: next_readdata = {24'h000000, hold_count_before_vsync};
        OFF_HOLD_AFTER: next_readdata = {24'h000000, hold_count_after_vsync};
        OFF_FACTORY_TEST: next_readdata = {24'h000000, factory_test};
        OFF_MISC_CTRL: next_readdata = {24'h000000, misc_ctrl};
        OFF_POL_FORCE: next_readdata = {24'h000000, pol_force};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_separator_count_limit <= RST_SEP_LIMIT;
      control_bits_a <= RST_CTRL_A;
      control_bits_b <= RST_CTRL_B;
      hold_count_before_vsync <= RST_HOLD;
      hold_count_after_vsync <= RST_HOLD;
      factory_test <= RST_FACTORY_TEST;
      misc_ctrl <= RST_MISC_CTRL;
      pol_force <= RST_POL_FORCE;
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
    end else begin
      sync_separator_count_limit <= next_sep_limit;
      control_bits_a <= next_ctrl_a;
      control_bits_b <= next_ctrl_b;
      hold_count_before_vsync <= next_hold_before;
      hold_count_after_vsync <= next_hold_after;
      factory_test <= next_test;
      misc_ctrl <= next_misc;
      pol_force <= next_force;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end

  // polarity detection
  logic hsync_det, vsync_det, coast_det;
  polarity_detect u_hs (.clock(clock), .reset(reset), .level(pins.hsync),
    .active_high(hsync_det));
  polarity_detect u_vs (.clock(clock), .reset(reset), .level(pins.vsync),
    .active_high(vsync_det));
  polarity_detect u_cs (.clock(clock), .reset(reset), .level(pins.coast),
    .active_high(coast_det));

  assign pol_status.hsync_high = hsync_det;
  assign pol_status.vsync_out_low = ~vsync_det;
  assign pol_status.coast_high = coast_det;

  logic hsync_pol, coast_pol;
  assign hsync_pol = control_bits_a[BIT_HSYNC_POL_OVR] ?
    pol_force[BIT_FORCE_HSYNC_POL] : hsync_det;
  assign coast_pol = control_bits_a[BIT_COAST_POL_OVR] ?
    pol_force[BIT_FORCE_COAST_POL] : coast_det;

  // normalised active-high sync levels
  logic hs_act, vs_act, cs_act, hs_prev;
  assign hs_act = pins.hsync ~^ hsync_pol;
  assign vs_act = pins.vsync ~^ vsync_det;
  assign cs_act = pins.coast ~^ coast_pol;

  // sync separator on the hsync line
  logic [7:0] sep_count, next_sep_count;
  logic next_sep_vsync;
  always_comb begin
    next_sep_vsync = sep_vsync;
    next_sep_count = 8'h00;
    if (hs_act != sep_vsync) begin
      next_sep_count = sep_count + 8'h01;
      if (sep_count >= sync_separator_count_limit) begin
        next_sep_vsync = hs_act;
        next_sep_count = 8'h00;
      end
    end
  end

  // coast window counting hsyncs around vsync
  logic [7:0] line_count, next_line_count;
  logic [7:0] frame_lines, next_frame_lines;
  logic [7:0] post_left, next_post_left;
  logic vs_prev, hs_edge, vs_rise, vs_fall;
  logic coast_window, next_coast;
  assign hs_edge = hs_act & ~hs_prev;
  assign vs_rise = vs_act & ~vs_prev;
  assign vs_fall = ~vs_act & vs_prev;

  always_comb begin
    next_line_count = line_count;
    next_frame_lines = frame_lines;
    next_post_left = post_left;
    if (vs_rise) begin
      next_frame_lines = line_count;
      next_line_count = 8'h00;
    end else if (hs_edge && line_count != 8'hFF) begin
      next_line_count = line_count + 8'h01;
    end
    if (vs_fall) begin
      next_post_left = hold_count_after_vsync;
    end else if (hs_edge && post_left != 8'h00) begin
      next_post_left = post_left - 8'h01;
    end
    // pre window: last N lines of the previous frame length
    coast_window = vs_act || post_left != 8'h00 ||
      (hold_count_before_vsync != 8'h00 &&
       {1'b0, line_count} + {1'b0, hold_count_before_vsync} >
       {1'b0, frame_lines});
    next_coast = misc_ctrl[BIT_COAST_SEL] ? coast_window : cs_act;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sep_count <= 8'h00;
      sep_vsync <= 1'b0;
      line_count <= 8'h00;
      frame_lines <= 8'hFF;
      post_left <= 8'h00;
      hs_prev <= 1'b0;
      vs_prev <= 1'b0;
      pll_coast <= 1'b0;
      chip_sleep_n <= 1'b1;
      scan_enable <= 1'b0;
      slicer_threshold <= RST_CTRL_B[7:3];
    end else begin
      sep_count <= next_sep_count;
      sep_vsync <= next_sep_vsync;
      line_count <= next_line_count;
      frame_lines <= next_frame_lines;
      post_left <= next_post_left;
      hs_prev <= hs_act;
      vs_prev <= vs_act;
      pll_coast <= next_coast & misc_ctrl[BIT_SLEEP_N];
      chip_sleep_n <= misc_ctrl[BIT_SLEEP_N];
      scan_enable <= control_bits_a[BIT_SCAN_EN];
      slicer_threshold <= control_bits_b[7:SLICER_LSB];
    end
  end

  a_sleep_follows: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> chip_sleep_n == $past(misc_ctrl[BIT_SLEEP_N]))
    else $error("sleep output does not follow control");

  a_coast_pin_path: assert property (@(posedge clock) disable iff (reset)
    !misc_ctrl[BIT_COAST_SEL] && misc_ctrl[BIT_SLEEP_N] |=> pll_coast == $past(cs_act))
    else $error("coast pin not routed");

  a_status_write_ignored: assert property (@(posedge clock) disable iff (reset)
    wr_ok && address == OFF_POL_STATUS |=> $stable(pol_force) && $stable(control_bits_a))
    else $error("status write disturbed state");

  a_post_hold_load: assert property (@(posedge clock) disable iff (reset)
    vs_fall |=> post_left == $past(hold_count_after_vsync))
    else $error("post coast count not loaded");

  a_sep_threshold: assert property (@(posedge clock) disable iff (reset)
    $changed(sep_vsync) |-> $past(sep_count) >= $past(sync_separator_count_limit))
    else $error("separator toggled early");

  a_hsync_override: assert property (@(posedge clock) disable iff (reset)
    control_bits_a[BIT_HSYNC_POL_OVR] |-> hsync_pol == pol_force[BIT_FORCE_HSYNC_POL])
    else $error("hsync override ignored");
endmodule

// >>> sync_coast_pkg.sv
package sync_coast_pkg;

  localparam int ADDR_W = 5;

  // word offsets (byte address = offset * 4)
  localparam logic [ADDR_W-1:0] OFF_SEP_LIMIT = 5'h13;
  localparam logic [ADDR_W-1:0] OFF_CTRL_A = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_POL_STATUS = 5'h15;
  localparam logic [ADDR_W-1:0] OFF_CTRL_B = 5'h16;
  localparam logic [ADDR_W-1:0] OFF_HOLD_BEFORE = 5'h17;
  localparam logic [ADDR_W-1:0] OFF_HOLD_AFTER = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_FACTORY_TEST = 5'h19;
  localparam logic [ADDR_W-1:0] OFF_MISC_CTRL = 5'h1A;
  localparam logic [ADDR_W-1:0] OFF_POL_FORCE = 5'h1B;

  // misc control (coast select, sleep)
  localparam int BIT_COAST_SEL = 1;
  localparam int BIT_SLEEP_N = 0;
  // control_bits_a fields
  localparam int BIT_SCAN_EN = 2;
  localparam int BIT_COAST_POL_OVR = 1;
  localparam int BIT_HSYNC_POL_OVR = 0;
  // forced polarity register fields
  localparam int BIT_FORCE_HSYNC_POL = 7;
  localparam int BIT_FORCE_COAST_POL = 6;
  // status fields, and the control_b slicer threshold lsb
  localparam int BIT_ST_HSYNC = 7;
  localparam int BIT_ST_VSYNC = 6;
  localparam int BIT_ST_COAST = 5;
  localparam int SLICER_LSB = 3;

  localparam logic [7:0] RST_SEP_LIMIT = 8'h20;
  localparam logic [7:0] RST_CTRL_A = 8'h10;
  localparam logic [7:0] RST_CTRL_B = 8'hB8;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_FACTORY_TEST = 8'h00;
  localparam logic [7:0] RST_MISC_CTRL = 8'h01;
  localparam logic [7:0] RST_POL_FORCE = 8'h00;

  // polarity window counter width, 4096-clock window, 4095 samples per estimate
  localparam int POL_WIN_W = 12;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic coast;
  } sync_in_t;

  typedef struct packed {
    logic hsync_high;
    logic vsync_out_low;
    logic coast_high;
  } pol_status_t;

endpackage

// >>> polarity_detect.sv
`timescale 1ns/1ps
module polarity_detect (
  input wire logic clock,
  input wire logic reset,
  input wire logic level,
  output logic active_high
);
  import sync_coast_pkg::*;

  logic [POL_WIN_W-1:0] count;
  logic [POL_WIN_W-1:0] high_count;
  logic [POL_WIN_W-1:0] next_count;
  logic [POL_WIN_W-1:0] next_high_count;
  logic next_active_high;

  // pulse is the minority level within a window
  always_comb begin
    next_count = count + 1'b1;
    next_high_count = high_count + {{(POL_WIN_W-1){1'b0}}, level};
    next_active_high = active_high;
    if (&count) begin
      next_active_high = (high_count[POL_WIN_W-1] == 1'b0);
      next_high_count = '0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= '0;
      high_count <= '0;
      active_high <= 1'b0;
    end else begin
      count <= next_count;
      high_count <= next_high_count;
      active_high <= next_active_high;
    end
  end
endmodule

// >>> sync_source_model.sv
`timescale 1ns/1ps
module sync_source_model (
  input wire logic clock,
  input wire logic hs_pol,
  input wire logic cs_pol,
  output sync_coast_pkg::sync_in_t pins,
  output logic [3:0] line_no,
  output logic [5:0] col
);
  import sync_coast_pkg::*;
  // 64-clock lines, 16-line frames, vsync on lines 8-9, coast pin on lines 2-3
  initial begin
    line_no = 4'h0;
    col = 6'h00;
  end
  always_ff @(posedge clock) begin
    col <= col + 6'h01;
    if (col == 6'h3F) begin
      line_no <= line_no + 4'h1;
    end
  end
  assign pins.hsync = (col < 6'h06) ~^ hs_pol;
  assign pins.vsync = (line_no[3:1] == 3'h4);
  assign pins.coast = (line_no[3:1] == 3'h1) ~^ cs_pol;
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import sync_coast_pkg::*;
  logic clock, reset, read, write, hs_pol, cs_pol;
  logic waitrequest, pll_coast, chip_sleep_n, scan_enable, sep_vsync;
  logic [ADDR_W-1:0] address;
  logic [31:0] writedata, readdata;
  logic [4:0] slicer_threshold;
  logic [7:0] factory_test, q;
  logic [3:0] line_no;
  logic [5:0] col;
  sync_in_t pins;
  int err_count, check_count;
  logic [ADDR_W-1:0] ra [8] = '{OFF_SEP_LIMIT, OFF_CTRL_A, OFF_CTRL_B, OFF_HOLD_BEFORE,
    OFF_HOLD_AFTER, OFF_FACTORY_TEST, OFF_MISC_CTRL, OFF_POL_FORCE};
  logic [7:0] rv [8] = '{8'h20, 8'h10, 8'hB8, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

  sync_coast_control_regs dut_u (.clock(clock), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .sync_pins(pins),
    .pll_coast(pll_coast), .chip_sleep_n(chip_sleep_n), .scan_enable(scan_enable),
    .sep_vsync(sep_vsync), .slicer_threshold(slicer_threshold),
    .factory_test(factory_test));
  sync_source_model src_u (.clock(clock), .hs_pol(hs_pol), .cs_pol(cs_pol),
    .pins(pins), .line_no(line_no), .col(col));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h000000, d};
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0) begin
      err_count++;
      $display("BAD %0t: no answer", $time);
    end
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  // wait for the middle of a given line
  task automatic at(input logic [3:0] l);
    do @(posedge clock); while (line_no !== l || col !== 6'h20);
  endtask
  task automatic pol(input logic h, input logic c);
    hs_pol <= h;
    cs_pol <= c;
    repeat (9000) @(posedge clock);
    rd(OFF_POL_STATUS, {h, 1'b0, c, 5'h00});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    err_count++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    hs_pol = 1'b1;
    cs_pol = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk({chip_sleep_n, scan_enable, slicer_threshold, pll_coast}, 8'hAE);
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(OFF_POL_STATUS, 8'h40);
    foreach (ra[i]) begin
      if (i != 1 && i < 6) begin
        wr(ra[i], (i == 2) ? 8'hFB : 8'hFF);
        rd(ra[i], (i == 2) ? 8'hF8 : 8'hFF);
      end
    end
    chk(factory_test, 8'hFF);
    chk(slicer_threshold, 8'h1F);
    foreach (ra[i]) if (i != 1 && i < 6) wr(ra[i], rv[i]);
    chk(slicer_threshold, 8'h17);
    rd(5'h00, 8'h00);
    wr(5'h00, 8'hFF);
    rd(5'h00, 8'h00);
    wr(OFF_CTRL_A, 8'h14);
    chk(scan_enable, 8'h01);
    wr(OFF_CTRL_A, 8'h10);
    chk(scan_enable, 8'h00);
    pol(1'b1, 1'b1);
    wr(OFF_POL_STATUS, 8'h40);
    rd(OFF_POL_STATUS, 8'hA0);
    pol(1'b0, 1'b0);
    pol(1'b1, 1'b0);
    pol(1'b1, 1'b1);
    at(2);
    chk(pll_coast, 8'h01);
    at(5);
    chk(pll_coast, 8'h00);
    wr(OFF_MISC_CTRL, 8'h00);
    chk(chip_sleep_n, 8'h00);
    at(2);
    chk(pll_coast, 8'h00);
    wr(OFF_MISC_CTRL, 8'h01);
    chk(chip_sleep_n, 8'h01);
    wr(OFF_CTRL_A, 8'h12);
    at(2);
    chk(pll_coast, 8'h00);
    at(5);
    chk(pll_coast, 8'h01);
    wr(OFF_CTRL_A, 8'h10);
    wr(OFF_MISC_CTRL, 8'h03);
    at(0);
    at(7);
    chk(pll_coast, 8'h00);
    at(8);
    chk(pll_coast, 8'h01);
    at(10);
    chk(pll_coast, 8'h00);
    wr(OFF_HOLD_BEFORE, 8'h02);
    wr(OFF_HOLD_AFTER, 8'h02);
    at(0);
    at(5);
    chk(pll_coast, 8'h00);
    at(7);
    chk(pll_coast, 8'h01);
    at(10);
    chk(pll_coast, 8'h01);
    at(13);
    chk(pll_coast, 8'h00);
    print_verdict();
  end
endmodule
